// ### lvr_pkg.sv
// package: constants and carrier types for the low-voltage and runaway reset block
package lvr_pkg;

   // ==========================================================
   // supervision counter
   localparam int unsigned SUP_WIDTH = 20;
   localparam logic [19:0] SUP_RESET_VAL = 20'h00000;
   localparam logic [19:0] SUP_LAST = 20'hFFFFF;

   // ==========================================================
   // internal reset pulse
   localparam int unsigned RST_PULSE_NS = 1000;
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned RST_PULSE_CYC =
      (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] RST_CNT_LOAD = 4'(RST_PULSE_CYC);

   // ==========================================================
   // reset cause bit positions in the cause vector
   localparam int unsigned CAUSE_LV_BIT = 0;
   localparam int unsigned CAUSE_SUP_BIT = 1;

   // ==========================================================
   // software side requests
   typedef struct packed {
      logic sup_clear;
      logic flag_clear;
   } sw_req_t;

   // status toward software
   typedef struct packed {
      logic low_voltage_detect_flag;
      logic sup_expired_flag;
   } sw_stat_t;

endpackage

// ### sup_counter.sv
// supervision counter: 20-bit runaway timer clocked on oscillator ticks
`timescale 1ns/100ps
module sup_counter
   import lvr_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic osc_tick,
   input wire logic clear,
   output logic expire
);

   // ==========================================================
   // count
   logic [19:0] count_q;
   logic [19:0] count_d;
   logic expire_q;
   logic expire_d;

   always_comb begin
      count_d = count_q;
      expire_d = 1'b0;
      if (clear) begin
         count_d = SUP_RESET_VAL;
      end else if (osc_tick) begin
         if (count_q == SUP_LAST) begin
            expire_d = 1'b1;
            count_d = SUP_RESET_VAL;
         end else begin
            count_d = count_q + 20'h00001;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         count_q <= SUP_RESET_VAL;
         expire_q <= 1'b0;
      end else if (clk_en) begin
         count_q <= count_d;
         expire_q <= expire_d;
      end
   end

   assign expire = expire_q;

   // ==========================================================
   // checks
   property p_clear_zero;
      @(posedge clk) disable iff (!reset_n)
      (clk_en && clear) |=> (count_q == SUP_RESET_VAL);
   endproperty
   a_clear_zero: assert property (p_clear_zero)
      else $error("counter not zero after clear");

   property p_wrap_expire;
      @(posedge clk) disable iff (!reset_n)
      (clk_en && !clear && osc_tick && count_q == SUP_LAST) |=> expire_q;
   endproperty
   a_wrap_expire: assert property (p_wrap_expire)
      else $error("no expiry at terminal count");

   // only the rising edge is judged: a frozen clk_en holds expire_q while the count has moved on
   property p_no_spurious;
      @(posedge clk) disable iff (!reset_n)
      $rose(expire_q) |-> ($past(count_q) == SUP_LAST);
   endproperty
   a_no_spurious: assert property (p_no_spurious)
      else $error("expiry without terminal count");

endmodule // sup_counter

// ### lvr_reset.sv
// top: low-voltage detect reset and runaway supervision reset
//
// Summary of operation
// - low supply asserts internal reset
// - low supply sets detection flag to one
// - detection works in stop, reset exits stop
// - 20-bit oscillator counter resets unless cleared
`timescale 1ns/100ps
module lvr_reset
   import lvr_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic osc_tick,
   input wire logic low_supply,
   input wire logic stop_mode,
   input wire sw_req_t sw_req,
   output sw_stat_t sw_stat,
   output logic int_reset,
   output logic stop_release
);

   // ==========================================================
   // reset pulse state
   typedef enum logic [1:0] {
      ST_RUN = 2'b01,
      ST_RST = 2'b10
   } state_t;

   state_t state_q;
   state_t state_d;
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic int_reset_q;
   logic int_reset_d;
   logic release_q;
   logic release_d;
   logic lv_flag_q;
   logic lv_flag_d;
   logic sup_flag_q;
   logic sup_flag_d;
   logic sup_expire;
   logic sup_clear;

   // the counter is held clear while internal reset stands, so it
   // restarts its full interval from the release
   assign sup_clear = sw_req.sup_clear | int_reset_q;

   sup_counter i_sup_counter (
      .clk(clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .osc_tick(osc_tick),
      .clear(sup_clear),
      .expire(sup_expire)
   );

   // ==========================================================
   // sequencer: no gating by stop_mode, detection stays live in stop
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      release_d = 1'b0;
      unique case (state_q)
         ST_RUN: begin
            if (low_supply || sup_expire) begin
               state_d = ST_RST;
               cnt_d = RST_CNT_LOAD;
               release_d = stop_mode;
            end
         end
         ST_RST: begin
            if (low_supply) begin
               cnt_d = RST_CNT_LOAD;
            end else if (cnt_q == 4'h1) begin
               state_d = ST_RUN;
               cnt_d = 4'h0;
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
      endcase
      int_reset_d = (state_d == ST_RST);
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= ST_RUN;
         cnt_q <= 4'h0;
         int_reset_q <= 1'b0;
         release_q <= 1'b0;
      end else if (clk_en) begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         int_reset_q <= int_reset_d;
         release_q <= release_d;
      end
   end

   // ==========================================================
   // cause flags: set beats clear
   always_comb begin
      lv_flag_d = lv_flag_q;
      sup_flag_d = sup_flag_q;
      if (sw_req.flag_clear) begin
         lv_flag_d = 1'b0;
         sup_flag_d = 1'b0;
      end
      if (low_supply) begin
         lv_flag_d = 1'b1;
      end
      if (sup_expire) begin
         sup_flag_d = 1'b1;
      end
   end

   // flags survive internal reset; only the external reset or sw_req.flag_clear clears them
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         lv_flag_q <= 1'b0;
         sup_flag_q <= 1'b0;
      end else if (clk_en) begin
         lv_flag_q <= lv_flag_d;
         sup_flag_q <= sup_flag_d;
      end
   end

   assign int_reset = int_reset_q;
   assign stop_release = release_q;
   assign sw_stat.low_voltage_detect_flag = lv_flag_q;
   assign sw_stat.sup_expired_flag = sup_flag_q;

   // ==========================================================
   // checks
   property p_lv_reset;
      @(posedge clk) disable iff (!reset_n)
      (clk_en && low_supply) |=> int_reset_q;
   endproperty
   a_lv_reset: assert property (p_lv_reset)
      else $error("low supply without internal reset");

   property p_lv_flag;
      @(posedge clk) disable iff (!reset_n)
      (clk_en && low_supply) |=> lv_flag_q;
   endproperty
   a_lv_flag: assert property (p_lv_flag)
      else $error("detection flag not set");

   property p_stop_exit;
      @(posedge clk) disable iff (!reset_n)
      (clk_en && state_q == ST_RUN && low_supply && stop_mode)
         |=> (release_q && int_reset_q);
   endproperty
   a_stop_exit: assert property (p_stop_exit)
      else $error("stop not released on detection");

   property p_sup_reset;
      @(posedge clk) disable iff (!reset_n)
      (clk_en && sup_expire) |=> (int_reset_q && sup_flag_q);
   endproperty
   a_sup_reset: assert property (p_sup_reset)
      else $error("expiry without internal reset");

   property p_pulse_len;
      @(posedge clk) disable iff (!reset_n)
      ($rose(int_reset_q) && clk_en) ##0 (!low_supply && clk_en) [*3]
         |=> int_reset_q;
   endproperty
   a_pulse_len: assert property (p_pulse_len)
      else $error("internal reset too short");

   property p_reset_clears;
      @(posedge clk) disable iff (!reset_n)
      int_reset_q |-> sup_clear;
   endproperty
   a_reset_clears: assert property (p_reset_clears)
      else $error("counter not held during reset");

   property p_flag_hold;
      @(posedge clk) disable iff (!reset_n)
      (clk_en && lv_flag_q && !sw_req.flag_clear) |=> lv_flag_q;
   endproperty
   a_flag_hold: assert property (p_flag_hold)
      else $error("detection flag lost");

   property p_release_cause;
      @(posedge clk) disable iff (!reset_n)
      release_q |-> int_reset_q;
   endproperty
   a_release_cause: assert property (p_release_cause)
      else $error("stop release without reset");

   c_lv: cover property (@(posedge clk) disable iff (!reset_n) $rose(lv_flag_q));
   c_sup: cover property (@(posedge clk) disable iff (!reset_n) $rose(sup_flag_q));
   c_stop: cover property (@(posedge clk) disable iff (!reset_n) release_q);
   c_end: cover property (@(posedge clk) disable iff (!reset_n) $fell(int_reset_q));

endmodule // lvr_reset

// ### tb_lvr_reset.sv
// testbench: self-checking bench for the low-voltage and runaway reset block
`timescale 1ns/100ps
module tb_lvr_reset;
   import lvr_pkg::*;
   // ==========================================================
   // stimulus and wiring
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic clk_en = 1'b1;
   logic osc_tick = 1'b0;
   logic low_supply = 1'b0;
   logic stop_mode = 1'b0;
   sw_req_t sw_req = '0;
   sw_stat_t sw_stat;
   logic int_reset;
   logic stop_release;
   int n_fail = 0;
   int n_tests = 0;
   int cyc = 0;
   // the supervision walk needs about 40000 cycles, the rest about a hundred
   localparam int CEIL = 60000;

   always #50 clk = ~clk;

   lvr_reset i_lvr_reset (
      .clk(clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .osc_tick(osc_tick),
      .low_supply(low_supply),
      .stop_mode(stop_mode),
      .sw_req(sw_req),
      .sw_stat(sw_stat),
      .int_reset(int_reset),
      .stop_release(stop_release)
   );

   // ==========================================================
   // shared tasks
   task automatic chk(input logic got, input logic exp, input string msg);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask

   task automatic nclk(input int n);
      repeat (n) @(negedge clk);
   endtask

   // bounded wait so a stuck reset cannot hang the run
   task automatic wait_release();
      for (int i = 0; i < 5 && int_reset !== 1'b0; i++) @(negedge clk);
      chk(int_reset, 1'b0, "internal reset not released");
   endtask

   task automatic end_of_test();
      if (n_fail == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == CEIL) begin
         n_fail++;
         end_of_test();
      end
   end

   // ==========================================================
   // scenarios
   task automatic t_low(input logic stop);
      @(negedge clk);
      stop_mode = stop;
      low_supply = 1'b1;
      @(negedge clk);
      chk(int_reset, 1'b1, "no reset on low supply");
      chk(sw_stat.low_voltage_detect_flag, 1'b1, "flag not set");
      chk(stop_release, stop, "stop release wrong");
      stop_mode = 1'b0;
      @(negedge clk);
      chk(stop_release, 1'b0, "stop release not a pulse");
      nclk(20);
      chk(int_reset, 1'b1, "reset dropped while supply low");
      low_supply = 1'b0;
      nclk(8);
      chk(int_reset, 1'b1, "reset pulse too short");
      wait_release();
   endtask

   // a set in the same cycle as a clear must win
   task automatic t_flag();
      @(negedge clk);
      sw_req.flag_clear = 1'b1;
      low_supply = 1'b1;
      @(negedge clk);
      chk(sw_stat.low_voltage_detect_flag, 1'b1, "clear beat set");
      low_supply = 1'b0;
      @(negedge clk);
      chk(sw_stat.low_voltage_detect_flag, 1'b0, "flag not cleared");
      sw_req.flag_clear = 1'b0;
      nclk(9);
      wait_release();
   endtask

   task automatic t_freeze();
      @(negedge clk);
      clk_en = 1'b0;
      low_supply = 1'b1;
      nclk(3);
      low_supply = 1'b0;
      @(negedge clk);
      clk_en = 1'b1;
      nclk(2);
      chk(int_reset, 1'b0, "reset while frozen");
      chk(sw_stat.low_voltage_detect_flag, 1'b0, "flag set while frozen");
   endtask

   // full expiry takes 2^20 ticks, past the run budget; this walks the clear path
   task automatic t_sup();
      @(negedge clk);
      osc_tick = 1'b1;
      for (int i = 0; i < 40; i++) begin
         nclk(1000);
         sw_req.sup_clear = 1'b1;
         @(negedge clk);
         sw_req.sup_clear = 1'b0;
         chk(int_reset, 1'b0, "early supervision reset");
         chk(sw_stat.sup_expired_flag, 1'b0, "early expiry flag");
      end
      osc_tick = 1'b0;
   endtask

   task automatic t_rearm();
      @(negedge clk);
      low_supply = 1'b1;
      nclk(3);
      reset_n = 1'b0;
      @(negedge clk);
      chk(int_reset, 1'b0, "reset output during reset");
      chk(sw_stat.low_voltage_detect_flag, 1'b0, "flag kept through reset");
      reset_n = 1'b1;
      nclk(2);
      chk(int_reset, 1'b1, "no reset after rearm");
      chk(sw_stat.low_voltage_detect_flag, 1'b1, "flag not set after rearm");
      low_supply = 1'b0;
      nclk(9);
      wait_release();
   endtask

   // ==========================================================
   // main sequence
   initial begin
      nclk(16);
      reset_n = 1'b1;
      @(negedge clk);
      chk(int_reset, 1'b0, "reset output after reset");
      chk(sw_stat.low_voltage_detect_flag, 1'b0, "flag after reset");
      t_low(1'b0);
      t_low(1'b1);
      t_flag();
      t_freeze();
      t_sup();
      t_rearm();
      end_of_test();
   end
endmodule // tb_lvr_reset
